// ===== hdl/spcfg_top.sv
// module: serial port protocol configuration registers and output pin steering
// Notes on behaviour
// - input protocol selector sits in bits 1:0 of input register, resets zero.
// - selector codes map to spi modes 0..3 as cpol,cpha pairs.
// - output selector upper bit zero: output uses input side polarity and phase.
// - output selector code 11 selects source-synchronous transmit protocol.
// - bit 6 picks source-synchronous clock: 0 external sclk, 1 internal.
// - clock select matters only in source-synchronous output mode.
// - pin function 00 (reset) tristates second pin, single data lane.
// - pin function 01 drives alarm on second pin, single lane.
// - pin function 10 makes second pin general output, single lane.
// - pin function 11 sends data on two lanes together.
// - general output pin follows bit 12, reset zero.
// - reserved bits of both registers read zero.
// - selectors and clock select clear only on power-on; pin fields also on application.
// - input register at byte 08h, output register at 0ch, little endian.
// - application reset clears user settings; power-on reset clears everything.
`timescale 1ns/1ps
`default_nettype none
module spcfg_top
  import spcfg_pkg::*;
(
  input  wire logic        ref_clk_i,           // 10 mhz clock
  input  wire logic        arst_n_i,            // power-on reset, async, active low
  input  wire logic        rst_pin_n_i,         // external reset pin, active low, async
  input  wire logic        alarm_i,             // alarm indication from converter
  input  wire logic [31:0] s_axi_awaddr,        // write address
  input  wire logic        s_axi_awvalid,       // write address valid
  output logic             s_axi_awready,       // write address ready
  input  wire logic [31:0] s_axi_wdata,         // write data
  input  wire logic [3:0]  s_axi_wstrb,         // write strobes
  input  wire logic        s_axi_wvalid,        // write data valid
  output logic             s_axi_wready,        // write data ready
  output logic [1:0]       s_axi_bresp,         // write response
  output logic             s_axi_bvalid,        // write response valid
  input  wire logic        s_axi_bready,        // write response ready
  input  wire logic [31:0] s_axi_araddr,        // read address
  input  wire logic        s_axi_arvalid,       // read address valid
  output logic             s_axi_arready,       // read address ready
  output logic [31:0]      s_axi_rdata,         // read data
  output logic [1:0]       s_axi_rresp,         // read response
  output logic             s_axi_rvalid,        // read data valid
  input  wire logic        s_axi_rready,        // read data ready
  output logic             spi_cpol_o,          // clock polarity for input and spi output
  output logic             spi_cpha_o,          // clock phase for input and spi output
  output logic             out_cpol_o,          // clock polarity used by output side
  output logic             out_cpha_o,          // clock phase used by output side
  output logic             srcsync_mode_o,      // output uses source-synchronous protocol
  output logic             srcsync_int_clk_o,   // source-synchronous clock is internal
  output logic             dual_lane_o,         // data shifted on both output lanes
  output logic             second_lane_o,       // second output pin value when not data
  output logic             second_lane_oe_o,    // second output pin enable
  output logic             second_lane_data_o,  // second pin carries serial data
  output logic             out_sel_invalid_o    // forbidden output selector programmed
);
  spcfg_wr_if wr ();

  logic [1:0]      input_protocol_selector;
  logic [1:0]      output_protocol_selector;
  logic            srcsync_clock_select;
  spcfg_pin_func_t second_pin_function;
  logic            general_output_level;
  logic            reset_pin_class_select;
  logic            rst_meta;
  logic            rst_sync;
  logic            app_reset;

  spcfg_axil_wr u_wr (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .awaddr_i  (s_axi_awaddr),
    .awvalid_i (s_axi_awvalid),
    .awready_o (s_axi_awready),
    .wdata_i   (s_axi_wdata),
    .wstrb_i   (s_axi_wstrb),
    .wvalid_i  (s_axi_wvalid),
    .wready_o  (s_axi_wready),
    .bresp_o   (s_axi_bresp),
    .bvalid_o  (s_axi_bvalid),
    .bready_i  (s_axi_bready),
    .wr        (wr.src)
  );

  // reset pin is asynchronous to the clock: two flops, only the second is read
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
    end else begin
      rst_meta <= rst_pin_n_i;
      rst_sync <= rst_meta;
    end
  end

  // pin acting as application reset clears only user fields while it is held low
  assign app_reset = reset_pin_class_select && !rst_sync;

  // class select lives in the reset control register; a pin-driven power-on class
  // reset while it is clear is handled by clearing everything below
  logic pin_por;
  assign pin_por = !reset_pin_class_select && !rst_sync;

  function automatic logic lane_hit(input logic [3:0] a, input logic [3:0] want,
                                    input logic [3:0] strb);
    lane_hit = wr.wr_en && (a == want) && strb[0];
  endfunction

  logic wr_in;
  logic wr_out_lo;
  logic wr_out_hi;
  logic wr_rst;
  assign wr_in     = lane_hit(wr.wr_addr, ADDR_INPUT_CFG, wr.wr_strb);
  assign wr_out_lo = lane_hit(wr.wr_addr, ADDR_OUTPUT_CFG, wr.wr_strb);
  assign wr_out_hi = wr.wr_en && (wr.wr_addr == ADDR_OUTPUT_CFG) && wr.wr_strb[1];
  assign wr_rst    = lane_hit(wr.wr_addr, ADDR_RESET_CTL, wr.wr_strb);

  // power-on class fields: survive an application reset
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      input_protocol_selector  <= IN_SEL_RESET;
      output_protocol_selector <= OUT_SEL_RESET;
      srcsync_clock_select     <= SRCSYNC_RESET;
    end else if (pin_por) begin
      input_protocol_selector  <= IN_SEL_RESET;
      output_protocol_selector <= OUT_SEL_RESET;
      srcsync_clock_select     <= SRCSYNC_RESET;
    end else begin
      if (wr_in) begin
        input_protocol_selector <= wr.wr_data[IN_SEL_LSB +: 2];
      end
      if (wr_out_lo) begin
        output_protocol_selector <= wr.wr_data[OUT_SEL_LSB +: 2];
        srcsync_clock_select     <= wr.wr_data[SRCSYNC_CLK_BIT];
      end
    end
  end

  // application class fields
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      second_pin_function  <= SPCFG_PIN_TRISTATE;
      general_output_level <= GEN_LEVEL_RESET;
    end else if (pin_por || app_reset) begin
      second_pin_function  <= SPCFG_PIN_TRISTATE;
      general_output_level <= GEN_LEVEL_RESET;
    end else if (wr_out_hi) begin
      second_pin_function  <= spcfg_pin_func_t'(wr.wr_data[PIN_FUNC_LSB +: 2]);
      general_output_level <= wr.wr_data[GEN_LEVEL_BIT];
    end
  end

  // class select holds until the next power cycle once set
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reset_pin_class_select <= RESET_CLASS_RESET;
    end else if (wr_rst && wr.wr_data[RESET_CLASS_BIT]) begin
      reset_pin_class_select <= 1'b1;
    end
  end

  // pin and protocol outputs, all registered
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      spi_cpol_o         <= 1'b0;
      spi_cpha_o         <= 1'b0;
      out_cpol_o         <= 1'b0;
      out_cpha_o         <= 1'b0;
      srcsync_mode_o     <= 1'b0;
      srcsync_int_clk_o  <= 1'b0;
      dual_lane_o        <= 1'b0;
      second_lane_o      <= 1'b0;
      second_lane_oe_o   <= 1'b0;
      second_lane_data_o <= 1'b0;
      out_sel_invalid_o  <= 1'b0;
    end else begin
      spi_cpol_o <= input_protocol_selector[1];
      spi_cpha_o <= input_protocol_selector[0];
      // spi timing follows the input side whenever the upper selector bit is clear
      out_cpol_o <= output_protocol_selector[1] ? 1'b0 : input_protocol_selector[1];
      out_cpha_o <= output_protocol_selector[1] ? 1'b0 : input_protocol_selector[0];
      srcsync_mode_o <= (output_protocol_selector == OUT_SEL_SRCSYNC);
      // the clock choice is masked outside source-synchronous mode
      srcsync_int_clk_o <= (output_protocol_selector == OUT_SEL_SRCSYNC)
                           && srcsync_clock_select;
      // flagged only; the device cannot refuse a code software chose
      out_sel_invalid_o <= (output_protocol_selector == OUT_SEL_INVALID);
      case (second_pin_function)
        SPCFG_PIN_TRISTATE: begin
          dual_lane_o        <= 1'b0;
          second_lane_o      <= 1'b0;
          second_lane_oe_o   <= 1'b0;
          second_lane_data_o <= 1'b0;
        end
        SPCFG_PIN_ALARM: begin
          dual_lane_o        <= 1'b0;
          second_lane_o      <= alarm_i;
          second_lane_oe_o   <= 1'b1;
          second_lane_data_o <= 1'b0;
        end
        SPCFG_PIN_GENERAL: begin
          dual_lane_o        <= 1'b0;
          second_lane_o      <= general_output_level;
          second_lane_oe_o   <= 1'b1;
          second_lane_data_o <= 1'b0;
        end
        SPCFG_PIN_DUAL: begin
          dual_lane_o        <= 1'b1;
          second_lane_o      <= 1'b0;
          second_lane_oe_o   <= 1'b1;
          second_lane_data_o <= 1'b1;
        end
        default: begin
          dual_lane_o        <= 1'b0;
          second_lane_o      <= 1'b0;
          second_lane_oe_o   <= 1'b0;
          second_lane_data_o <= 1'b0;
        end
      endcase
    end
  end

  // read channel: one read in flight, answer one edge after the address is taken
  logic        rd_pend;
  logic [31:0] rd_addr;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready <= 1'b0;
      rd_pend       <= 1'b0;
      rd_addr       <= 32'h0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend <= 1'b1;
        rd_addr <= s_axi_araddr;
      end else if (!rd_pend && !s_axi_rvalid && s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_pend) begin
        rd_pend      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        s_axi_rdata  <= 32'h0;
        if (rd_addr[31:4] != 28'h0 || rd_addr[1:0] != 2'h0) begin
          s_axi_rresp <= RESP_SLVERR;
        end else if (rd_addr[3:0] == ADDR_INPUT_CFG) begin
          s_axi_rdata[IN_SEL_LSB +: 2] <= input_protocol_selector;
        end else if (rd_addr[3:0] == ADDR_OUTPUT_CFG) begin
          s_axi_rdata[OUT_SEL_LSB +: 2]  <= output_protocol_selector;
          s_axi_rdata[SRCSYNC_CLK_BIT]   <= srcsync_clock_select;
          s_axi_rdata[PIN_FUNC_LSB +: 2] <= second_pin_function;
          s_axi_rdata[GEN_LEVEL_BIT]     <= general_output_level;
        end else if (rd_addr[3:0] == ADDR_RESET_CTL) begin
          s_axi_rdata[RESET_CLASS_BIT] <= reset_pin_class_select;
        end else begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/spcfg_pkg.sv
// package: register map, fields, resets and codes of the serial port protocol configuration
package spcfg_pkg;
  localparam logic [3:0]  ADDR_INPUT_CFG    = 4'h8;
  localparam logic [3:0]  ADDR_OUTPUT_CFG   = 4'hc;
  localparam logic [3:0]  ADDR_RESET_CTL    = 4'h4;
  localparam int          IN_SEL_LSB        = 0;
  localparam int          OUT_SEL_LSB       = 0;
  localparam int          SRCSYNC_CLK_BIT   = 6;
  localparam int          PIN_FUNC_LSB      = 8;
  localparam int          GEN_LEVEL_BIT     = 12;
  localparam int          RESET_CLASS_BIT   = 2;
  localparam logic [1:0]  IN_SEL_RESET      = 2'h0;
  localparam logic [1:0]  OUT_SEL_RESET     = 2'h0;
  localparam logic        SRCSYNC_RESET     = 1'h0;
  localparam logic [1:0]  PIN_FUNC_RESET    = 2'h0;
  localparam logic        GEN_LEVEL_RESET   = 1'h0;
  localparam logic        RESET_CLASS_RESET = 1'h0;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
  localparam logic [1:0]  OUT_SEL_INVALID   = 2'h2;
  localparam logic [1:0]  OUT_SEL_SRCSYNC   = 2'h3;
  typedef enum logic [1:0] {
    SPCFG_PIN_TRISTATE = 2'h0,
    SPCFG_PIN_ALARM    = 2'h1,
    SPCFG_PIN_GENERAL  = 2'h2,
    SPCFG_PIN_DUAL     = 2'h3
  } spcfg_pin_func_t;
endpackage

// ===== hdl/spcfg_wr_if.sv
// interface: one accepted register write, carried from bus slave to register file
`timescale 1ns/1ps
`default_nettype none
interface spcfg_wr_if;
  logic        wr_en;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  modport src (output wr_en, output wr_addr, output wr_data, output wr_strb);
  modport dst (input wr_en, input wr_addr, input wr_data, input wr_strb);
endinterface
`default_nettype wire

// ===== hdl/spcfg_axil_wr.sv
// module: axi4-lite write channel handling, address and data taken in either order
`timescale 1ns/1ps
`default_nettype none
module spcfg_axil_wr
  import spcfg_pkg::*;
(
  input  wire logic        ref_clk_i,     // 10 mhz clock
  input  wire logic        arst_n_i,      // async reset, active low
  input  wire logic [31:0] awaddr_i,      // write address
  input  wire logic        awvalid_i,     // write address valid
  output logic             awready_o,     // write address ready
  input  wire logic [31:0] wdata_i,       // write data
  input  wire logic [3:0]  wstrb_i,       // write byte strobes
  input  wire logic        wvalid_i,      // write data valid
  output logic             wready_o,      // write data ready
  output logic [1:0]       bresp_o,       // write response
  output logic             bvalid_o,      // write response valid
  input  wire logic        bready_i,      // write response ready
  spcfg_wr_if.src          wr             // accepted write toward registers
);
  logic        have_addr;
  logic        have_data;
  logic [31:0] addr_q;
  logic [31:0] data_q;
  logic [3:0]  strb_q;

  // ready is held low while a response waits, so only one write is in flight
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      have_addr <= 1'b0;
      have_data <= 1'b0;
      addr_q    <= 32'h0;
      data_q    <= 32'h0;
      strb_q    <= 4'h0;
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
    end else begin
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
      if (awvalid_i && awready_o) begin
        have_addr <= 1'b1;
        addr_q    <= awaddr_i;
      end else if (!have_addr && !bvalid_o && awvalid_i) begin
        awready_o <= 1'b1;
      end
      if (wvalid_i && wready_o) begin
        have_data <= 1'b1;
        data_q    <= wdata_i;
        strb_q    <= wstrb_i;
      end else if (!have_data && !bvalid_o && wvalid_i) begin
        wready_o <= 1'b1;
      end
      if (have_addr && have_data) begin
        have_addr <= 1'b0;
        have_data <= 1'b0;
      end
    end
  end

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:4] == 28'h0) && (a[1:0] == 2'h0) &&
             (a[3:0] == ADDR_INPUT_CFG || a[3:0] == ADDR_OUTPUT_CFG ||
              a[3:0] == ADDR_RESET_CTL);
  endfunction

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_o   <= 1'b0;
      bresp_o    <= RESP_OKAY;
      wr.wr_en   <= 1'b0;
      wr.wr_addr <= 4'h0;
      wr.wr_data <= 32'h0;
      wr.wr_strb <= 4'h0;
    end else begin
      wr.wr_en <= 1'b0;
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
      if (have_addr && have_data) begin
        wr.wr_en   <= mapped(addr_q);
        wr.wr_addr <= addr_q[3:0];
        wr.wr_data <= data_q;
        wr.wr_strb <= strb_q;
        bvalid_o   <= 1'b1;
        bresp_o    <= mapped(addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/spcfg_props.sv
// checker: port-level relations of the protocol configuration block
`timescale 1ns/1ps
`default_nettype none
module spcfg_props (
  input wire logic        ref_clk_i,          // clock
  input wire logic        arst_n_i,           // power-on reset
  input wire logic        s_axi_bvalid,       // write response valid
  input wire logic        s_axi_bready,       // write response ready
  input wire logic [1:0]  s_axi_bresp,        // write response
  input wire logic        s_axi_rvalid,       // read valid
  input wire logic        s_axi_rready,       // read ready
  input wire logic [31:0] s_axi_rdata,        // read data
  input wire logic        spi_cpol_o,         // input polarity
  input wire logic        spi_cpha_o,         // input phase
  input wire logic        out_cpol_o,         // output polarity
  input wire logic        out_cpha_o,         // output phase
  input wire logic        srcsync_mode_o,     // source-synchronous
  input wire logic        srcsync_int_clk_o,  // internal clock
  input wire logic        dual_lane_o,        // two lanes
  input wire logic        second_lane_o,      // second pin value
  input wire logic        second_lane_oe_o,   // second pin enable
  input wire logic        second_lane_data_o, // second pin is data
  input wire logic        out_sel_invalid_o   // forbidden selector
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_out_follow;
    !srcsync_mode_o && !out_sel_invalid_o |-> out_cpol_o == spi_cpol_o && out_cpha_o == spi_cpha_o;
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("output mode not following input");
  property p_out_upper;
    srcsync_mode_o || out_sel_invalid_o |-> !out_cpol_o && !out_cpha_o;
  endproperty
  a_out_upper: assert property (p_out_upper) else $error("spi timing kept in upper modes");
  property p_exclusive;
    !(srcsync_mode_o && out_sel_invalid_o);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("invalid and srcsync together");
  property p_clk_gate;
    srcsync_int_clk_o |-> srcsync_mode_o;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("clock select outside srcsync");
  property p_dual;
    dual_lane_o |-> second_lane_oe_o && second_lane_data_o;
  endproperty
  a_dual: assert property (p_dual) else $error("dual lane without second pin data");
  property p_data_pin;
    second_lane_data_o == dual_lane_o;
  endproperty
  a_data_pin: assert property (p_data_pin) else $error("second pin data outside dual");
  property p_tristate;
    !second_lane_oe_o |-> !second_lane_o && !dual_lane_o;
  endproperty
  a_tristate: assert property (p_tristate) else $error("second pin active while off");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind spcfg_top spcfg_props u_spcfg_props (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .spi_cpol_o(spi_cpol_o),
  .spi_cpha_o(spi_cpha_o), .out_cpol_o(out_cpol_o), .out_cpha_o(out_cpha_o),
  .srcsync_mode_o(srcsync_mode_o), .srcsync_int_clk_o(srcsync_int_clk_o),
  .dual_lane_o(dual_lane_o), .second_lane_o(second_lane_o),
  .second_lane_oe_o(second_lane_oe_o), .second_lane_data_o(second_lane_data_o),
  .out_sel_invalid_o(out_sel_invalid_o));
`default_nettype wire

// ===== sim/spcfg_host.sv
// partner: host controller model, axi4-lite master for the configuration registers
`timescale 1ns/1ps
`default_nettype none
module spcfg_host (
  input  wire logic        clk_i,     // bus clock
  output logic [31:0]      awaddr_o,  // write address
  output logic             awvalid_o, // write address valid
  input  wire logic        awready_i, // write address ready
  output logic [31:0]      wdata_o,   // write data
  output logic [3:0]       wstrb_o,   // write strobes
  output logic             wvalid_o,  // write data valid
  input  wire logic        wready_i,  // write data ready
  input  wire logic [1:0]  bresp_i,   // write response
  input  wire logic        bvalid_i,  // write response valid
  output logic             bready_o,  // write response ready
  output logic [31:0]      araddr_o,  // read address
  output logic             arvalid_o, // read address valid
  input  wire logic        arready_i, // read address ready
  input  wire logic [31:0] rdata_i,   // read data
  input  wire logic [1:0]  rresp_i,   // read response
  input  wire logic        rvalid_i,  // read valid
  output logic             rready_o   // read ready
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // ready is registered, so sampling it at the falling edge sees the value of the next rise
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] resp);
    logic pa, pw, b;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    while (pa || pw) begin
      @(negedge clk_i);
      if (awready_i) pa = 1'b0;
      if (wready_i) pw = 1'b0;
      @(posedge clk_i);
      if (!pa) awvalid_o <= 1'b0;
      if (!pw) wvalid_o <= 1'b0;
    end
    do begin
      @(negedge clk_i);
      b = bvalid_i;
      resp = bresp_i;
      @(posedge clk_i);
    end while (!b);
    // ready comes one cycle late, so the response must hold while it waits
    bready_o <= 1'b1;
    @(posedge clk_i);
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic p, r;
    p = 1'b1;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    while (p) begin
      @(negedge clk_i);
      p = !arready_i;
      @(posedge clk_i);
    end
    arvalid_o <= 1'b0;
    do begin
      @(negedge clk_i);
      r = rvalid_i;
      d = rdata_i;
      resp = rresp_i;
      @(posedge clk_i);
    end while (!r);
    rready_o <= 1'b1;
    @(posedge clk_i);
    rready_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// testbench: register access, mode decoding, pin steering and reset classes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spcfg_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        rst_pin_n_i = 1'b1;
  logic        alarm_i = 1'b1;
  wire  [31:0] awaddr, wdata, araddr, rdata;
  wire  [3:0]  wstrb;
  wire  [1:0]  bresp, rresp;
  wire         awvalid, awready, wvalid, wready, bvalid, bready;
  wire         arvalid, arready, rvalid, rready;
  wire  [10:0] pins;
  int          fail_count = 0;
  int          tests_run = 0;
  logic [31:0] d;
  logic [1:0]  r;
  logic [31:0] out_data [9] = '{32'h41, 32'h2, 32'h43, 32'h3, 32'h100, 32'h1200, 32'h200,
                                32'h1300, 32'hffff_ffff};
  logic [8:0]  out_pins [9] = '{9'h180, 9'h001, 9'h060, 9'h040, 9'h18c, 9'h18c, 9'h184,
                                9'h196, 9'h076};
  initial forever #50 ref_clk_i = ~ref_clk_i;
  spcfg_top u_spcfg_top (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .rst_pin_n_i(rst_pin_n_i), .alarm_i(alarm_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .spi_cpol_o(pins[10]), .spi_cpha_o(pins[9]), .out_cpol_o(pins[8]), .out_cpha_o(pins[7]),
    .srcsync_mode_o(pins[6]), .srcsync_int_clk_o(pins[5]), .dual_lane_o(pins[4]),
    .second_lane_o(pins[3]), .second_lane_oe_o(pins[2]), .second_lane_data_o(pins[1]),
    .out_sel_invalid_o(pins[0]));
  spcfg_host u_spcfg_host (
    .clk_i(ref_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // writes leave three edges for the register and the pin stage to settle
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
    u_spcfg_host.wr(a, v, s, r);
    chk(r, RESP_OKAY);
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    u_spcfg_host.rd(a, d, r);
    chk(d, exp);
    chk(r, RESP_OKAY);
  endtask
  task automatic pin_reset();
    @(posedge ref_clk_i);
    rst_pin_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rst_pin_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rchk(32'h8, 32'h0);
    rchk(32'hc, 32'h0);
    chk(pins, 11'h0);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(32'h8, 32'hffff_fffc | i);
      rchk(32'h8, i);
      chk(pins, {i[1:0], i[1:0], 7'h0});
    end
    $display("test input modes done");
    for (int i = 0; i < 9; i++) begin
      wr(32'hc, out_data[i]);
      rchk(32'hc, out_data[i] & 32'h0000_1343);
      chk(pins, {2'h3, out_pins[i]});
    end
    wr(32'hc, 32'h100);
    alarm_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk(pins[3:2], 2'h1);
    wr(32'hc, 32'h0);
    wr(32'hc, 32'hffff_ffff, 4'h1);
    rchk(32'hc, 32'h43);
    $display("test output modes done");
    u_spcfg_host.rd(32'h20, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    u_spcfg_host.wr(32'h20, 32'hffff_ffff, 4'hf, r);
    chk(r, RESP_SLVERR);
    $display("test unmapped done");
    wr(32'hc, 32'h1343);
    pin_reset();
    rchk(32'h8, 32'h0);
    rchk(32'hc, 32'h0);
    wr(32'h4, 32'h4);
    wr(32'h8, 32'h3);
    wr(32'hc, 32'h1343);
    pin_reset();
    rchk(32'h8, 32'h3);
    rchk(32'hc, 32'h43);
    @(posedge ref_clk_i);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rchk(32'h8, 32'h0);
    rchk(32'hc, 32'h0);
    $display("test reset classes done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
